// >>> common/slf_pkg.sv
/*
 * slf_pkg: constants shared by the secure link frame builder.
 * Assumes a 125 MHz system clock and a data-rate bit enable derived from it.
 */
package slf_pkg;

   // system clock and durations
   localparam int unsigned CLK_HZ              = 125000000;
   localparam int unsigned BITSYNC_MIN_US      = 65000;      // 0.065 s
   localparam int unsigned BITSYNC_MAX_US      = 1500000;    // 1.5 s
   localparam int unsigned PHASING_MAX_MS      = 10000;      // 10.000 s

   // repetition code
   localparam int unsigned REP_LEN             = 15;
   localparam logic [14:0] REP_ONE_PAT         = 15'h09af;   // 000100110101111
   localparam logic [14:0] REP_ZERO_PAT        = 15'h7650;   // 111011001010000
   localparam int unsigned SYNC_BITS           = 31;
   localparam int unsigned SYNC_LEN            = 465;
   localparam logic [30:0] SYNC_WORD_RST       = 31'h3fffffff;

   // field widths
   localparam int unsigned BITCNT_W            = 32;
   localparam int unsigned DIV_W               = 16;
   localparam int unsigned MI_LEN_W            = 8;

   // frame sequencer states
   typedef enum logic [3:0] {
      SLF_IDLE    = 4'h0,
      SLF_BITSYNC = 4'h1,
      SLF_FSYNC   = 4'h2,
      SLF_MI      = 4'h3,
      SLF_PHASE   = 4'h4,
      SLF_TSYNC   = 4'h5,
      SLF_DATA    = 4'h6,
      SLF_POST    = 4'h7
   } slf_state_t;

endpackage : slf_pkg

// >>> verif/slf_fb_checker.sv
/* slf_fb_checker: port assertions for the frame builder.
   assumes a bind onto slf_frame_builder and the slf_pkg field codes. */
module slf_fb_checker
   import slf_pkg::*;
(
   input  wire logic                i_mclk,         // clock
   input  wire logic                i_resetn,       // reset, low
   input  wire logic [DIV_W-1:0]    i_bit_div,      // half bit
   input  wire logic                i_start,        // start
   input  wire logic [BITCNT_W-1:0] i_bitsync_bits, // bitsync bits
   input  wire logic [MI_LEN_W-1:0] i_mi_bits,      // vector bits
   input  wire logic                o_mi_take,      // take
   input  wire logic                o_tsync_take,   // take
   input  wire logic                o_data_take,    // take
   input  wire logic                o_post_take,    // take
   input  wire logic                o_tx_data,      // line
   input  wire logic                o_tx_clk,       // data-rate clock
   input  wire logic                o_busy,         // busy
   input  wire logic [3:0]          o_field         // field
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  fld_q;  // field of last clock
   logic [31:0] len_q;  // clocks spent in fld_q
   logic [31:0] run_q;  // clocks since line moved
   logic        tx_q;   // line of last clock
   logic        tk;     // any bit taken
   assign tk = o_mi_take | o_tsync_take | o_data_take | o_post_take;
   // field length and line run counters
   always_ff @(posedge i_mclk)
   begin
      fld_q <= o_field;
      len_q <= (o_field == fld_q) ? len_q + 1 : 32'h1;
      tx_q  <= o_tx_data;
      run_q <= (o_tx_data != tx_q) ? 32'h0 : run_q + 1;
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   a_start_bitsync: assert property (i_start && !o_busy |=> o_busy && o_field == SLF_BITSYNC)
      else $error("start not taken");
   a_field_step: assert property (o_busy && $past(o_busy) && o_field != fld_q |-> o_field == fld_q + 4'h1)
      else $error("field out of order");
   a_end_post: assert property ($fell(o_busy) |-> fld_q == SLF_POST)
      else $error("frame ended early");
   a_take_single: assert property (tk |=> !tk)
      else $error("take too long");
   a_take_onehot: assert property ($onehot0({o_mi_take, o_tsync_take, o_data_take, o_post_take}))
      else $error("two takes");
   a_bitsync_len: assert property (o_field == SLF_FSYNC && fld_q == SLF_BITSYNC |-> len_q == 2 * i_bit_div * i_bitsync_bits)
      else $error("bitsync length");
   a_fsync_len: assert property (o_field == SLF_MI && fld_q == SLF_FSYNC |-> len_q == SYNC_LEN * 2 * i_bit_div)
      else $error("sync length");
   a_vector_len: assert property (o_field == SLF_PHASE && fld_q == SLF_MI |-> len_q == 30 * i_bit_div * i_mi_bits)
      else $error("vector length");
   a_bitsync_clk: assert property (o_field == SLF_BITSYNC && fld_q == SLF_BITSYNC && len_q > 2 |-> run_q <= i_bit_div)
      else $error("bitsync line still");
   a_line_is_clock: assert property (o_field == SLF_BITSYNC && fld_q == SLF_BITSYNC
      |-> o_tx_data == $past(o_tx_clk))
      else $error("bitsync line not the bit clock");
endmodule : slf_fb_checker
bind slf_frame_builder slf_fb_checker i_chk (.*);

// >>> verif/slf_rx_model.sv
/* slf_rx_model: receiving station, samples each chip mid-bit.
   assumes the line lags the field code by one clock. */
module slf_rx_model
   import slf_pkg::*;
(
   input  wire logic             i_mclk,    // clock
   input  wire logic [DIV_W-1:0] i_bit_div, // half bit
   input  wire logic             i_line,    // serial line
   input  wire logic [3:0]       i_field,   // sender field
   output logic                  o_chip_ok, // chip seen
   output logic                  o_chip     // chip value
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  fld_q;  // field the line shows
   logic [31:0] pos_q;  // clocks into that field
   // restart the bit grid at every field start, sample mid-bit
   always_ff @(posedge i_mclk)
   begin
      fld_q     <= i_field;
      pos_q     <= (i_field != fld_q) ? 32'h0 : pos_q + 1;
      o_chip_ok <= fld_q >= SLF_FSYNC && fld_q <= SLF_POST && pos_q % (2 * i_bit_div) == i_bit_div;
      o_chip    <= i_line;
   end
endmodule : slf_rx_model

// >>> verif/testbench.sv
/* testbench: frame builder against a receiving station model.
   assumes slf_pkg, the design, the receiver model and the checker. */
module testbench
   import slf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                i_mclk = 0, i_resetn = 0, i_start = 0;
   logic [DIV_W-1:0]    i_bit_div = 16'h2;
   logic [BITCNT_W-1:0] i_bitsync_bits = 1, i_phasing_bits = 1, i_tsync_bits = 1, i_data_bits = 1, i_post_bits = 1;
   logic [30:0]         i_sync_word = 0;
   logic [MI_LEN_W-1:0] i_mi_bits = 1;
   logic                i_mi_bit, i_tsync_bit, i_data_bit, i_post_bit, chip_ok, chip;
   logic                o_mi_take, o_tsync_take, o_data_take, o_post_take, o_tx_data, o_tx_clk, o_busy, o_done;
   logic [3:0]          o_field;
   logic [255:0]        w [4];
   int                  n [4];
   logic                q [$];
   int                  fails = 0, check_count = 0;
   wire  [3:0]          tk = {o_post_take, o_data_take, o_tsync_take, o_mi_take};
   assign {i_post_bit, i_data_bit, i_tsync_bit, i_mi_bit} = {w[3][n[3]], w[2][n[2]], w[1][n[1]], w[0][n[0]]};
   always #4 i_mclk = ~i_mclk;
   slf_frame_builder i_dut (.*);
   slf_rx_model i_rx (.i_mclk(i_mclk), .i_bit_div(i_bit_div), .i_line(o_tx_data), .i_field(o_field),
                      .o_chip_ok(chip_ok), .o_chip(chip));
   // each take moves its source on to the next bit
   always @(posedge i_mclk)
      for (int j = 0; j < 4; j++)
         if (tk[j] === 1'b1)
            n[j] <= #1 n[j] + 1;
   task chk(input string what, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // oldest expected chip against each received chip
   always @(posedge i_mclk)
      if (chip_ok === 1'b1)
         chk("chip", (q.size() > 0) ? q.pop_front() : 1'bx, chip);
   task put(input logic b);
      for (int j = 14; j >= 0; j--)
         q.push_back(b ? REP_ONE_PAT[j] : REP_ZERO_PAT[j]);
   endtask : put
   task conclude;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   task pulse_start;
      i_start = 1;
      @(posedge i_mclk);
      #1;
      i_start = 0;
   endtask : pulse_start
   // one random frame, with a start pulse that must be ignored
   task frame;
      int cyc;
      cyc = 0;
      @(posedge i_mclk);
      #1;
      i_bit_div = 16'(2 + $urandom % 3);
      i_bitsync_bits = 1 + $urandom % 6;
      i_sync_word = 31'($urandom);
      i_mi_bits = 8'(1 + $urandom % 16);
      i_phasing_bits = 1 + $urandom % 9;
      i_tsync_bits = 1 + $urandom % 9;
      i_data_bits = 1 + $urandom % 40;
      i_post_bits = 1 + $urandom % 9;
      for (int j = 0; j < 4; j++)
      begin
         w[j] = {8{$urandom}};
         n[j] = 0;
      end
      for (int j = 30; j >= 0; j--) put(i_sync_word[j]);
      for (int j = 0; j < i_mi_bits; j++) put(w[0][j]);
      for (int j = 0; j < i_phasing_bits; j++) q.push_back(~j[0]);
      for (int j = 0; j < i_tsync_bits; j++) q.push_back(w[1][j]);
      for (int j = 0; j < i_data_bits; j++) q.push_back(w[2][j]);
      for (int j = 0; j < i_post_bits; j++) q.push_back(w[3][j]);
      pulse_start();
      repeat (300) @(posedge i_mclk);
      #1;
      pulse_start();
      while (o_done !== 1'b1 && cyc < 20000)
      begin
         @(posedge i_mclk);
         #1;
         cyc++;
      end
      chk("done", 1, o_done);
      repeat (8) @(posedge i_mclk);
      #1;
      chk("left", 0, q.size());
      chk("busy", 0, o_busy);
      chk("taken", i_mi_bits, n[0]);
      chk("tsync", i_tsync_bits, n[1]);
      chk("data", i_data_bits, n[2]);
      chk("post", i_post_bits, n[3]);
   endtask : frame
   initial
   begin
      void'($urandom(32'hc338d442));
      for (int j = 0; j < 4; j++)
         w[j] = {8{$urandom}};
      repeat (16) @(posedge i_mclk);
      #1;
      i_resetn = 1;
      repeat (3) frame();
      conclude();
   end
   // cut a hang short
   initial
   begin
      #(8 * 70000);
      fails++;
      conclude();
   end
endmodule : testbench

// >>> verilog/slf_frame_builder.sv
/*
 * slf_frame_builder: sends the traditional link-encryption frame on one
 * serial data line, one bit per data-rate period.
 * Assumes the terminal side supplies indicator bits, tsync, data and
 * postamble bits on request through one take strobe per source.
 */
module slf_frame_builder
   import slf_pkg::*;
(
   input  wire logic                i_mclk,          // 125 MHz clock
   input  wire logic                i_resetn,        // synchronous reset, active low
   input  wire logic [DIV_W-1:0]    i_bit_div,       // clocks per half data bit, min 1
   input  wire logic                i_start,         // request a frame (pulse)
   input  wire logic [BITCNT_W-1:0] i_bitsync_bits,  // bit-sync length in bit periods
   input  wire logic [30:0]         i_sync_word,     // frame-sync data word
   input  wire logic [MI_LEN_W-1:0] i_mi_bits,       // indicator bits to send
   input  wire logic [BITCNT_W-1:0] i_phasing_bits,  // phasing length in bit periods
   input  wire logic [BITCNT_W-1:0] i_tsync_bits,    // tsync length in bit periods
   input  wire logic [BITCNT_W-1:0] i_data_bits,     // data field length in bits
   input  wire logic [BITCNT_W-1:0] i_post_bits,     // postamble length in bits
   input  wire logic                i_mi_bit,        // next crypto_sync_vector bit
   input  wire logic                i_tsync_bit,     // next tsync bit
   input  wire logic                i_data_bit,      // next data field bit
   input  wire logic                i_post_bit,      // next keystream_unit postamble bit
   output logic                     o_mi_take,       // indicator bit consumed
   output logic                     o_tsync_take,    // tsync bit consumed
   output logic                     o_data_take,     // data bit consumed
   output logic                     o_post_take,     // postamble bit consumed
   output logic                     o_tx_data,       // serial line
   output logic                     o_tx_clk,        // data-rate clock
   output logic                     o_busy,          // frame in progress
   output logic [3:0]               o_field,         // current field code
   output logic                     o_done           // frame finished (pulse)
);

   slf_state_t          state_q;
   logic [DIV_W-1:0]    div_q;
   logic                half_q;
   logic                bit_en;
   logic [BITCNT_W-1:0] cnt_q;
   logic [4:0]          sidx_q;
   logic                phase_q;
   logic                tx_q;
   logic                enc_load;
   logic                enc_data;
   logic                enc_chip;
   logic                enc_last;
   logic                enc_mi;
   logic                last_bit;

   // half-bit divider; bit_en marks the last clock of each data bit
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn || state_q == SLF_IDLE)
      begin
         div_q  <= '0;
         half_q <= 1'b0;
      end
      else if (div_q + 16'h1 >= i_bit_div)
      begin
         div_q  <= '0;
         half_q <= ~half_q;
      end
      else
      begin
         div_q <= div_q + 16'h1;
      end
   end

   assign bit_en   = (state_q != SLF_IDLE) && half_q && (div_q + 16'h1 >= i_bit_div);
   assign o_tx_clk = ~half_q;
   assign last_bit = (cnt_q <= 32'h1);

   // feeds the repetition encoder; each group loads on the edge that ends the
   // previous bit, so no stale chip sits between fields
   assign enc_mi   = (state_q == SLF_MI) || (state_q == SLF_FSYNC && cnt_q == 32'h0);
   assign enc_data = enc_mi ? i_mi_bit : i_sync_word[30 - sidx_q];
   assign enc_load = bit_en && ((state_q == SLF_BITSYNC && last_bit) ||
                                (enc_last && (state_q == SLF_FSYNC ||
                                              (state_q == SLF_MI && cnt_q != 32'h0))));

   slf_rep_encoder u_enc (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .i_bit_en (bit_en),
      .i_load   (enc_load),
      .i_data   (enc_data),
      .o_chip   (enc_chip),
      .o_last   (enc_last)
   );

   // frame sequencer; a zero-length field still takes one bit, except a zero i_mi_bits, which wraps cnt_q
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         state_q <= SLF_IDLE;
         cnt_q   <= '0;
         sidx_q  <= 5'h00;
         phase_q <= 1'b1;
      end
      else
      begin
         case (state_q)
            SLF_IDLE:
            begin
               if (i_start)
               begin
                  state_q <= SLF_BITSYNC;
                  cnt_q   <= i_bitsync_bits;
                  sidx_q  <= 5'h00;
               end
            end
            SLF_BITSYNC:
            begin
               if (bit_en)
               begin
                  if (last_bit)
                  begin
                     state_q <= SLF_FSYNC;
                     cnt_q   <= 32'(SYNC_BITS) - 32'h1;              // first group loads now
                     sidx_q  <= 5'h01;
                  end
                  else
                  begin
                     cnt_q <= cnt_q - 32'h1;
                  end
               end
            end
            SLF_FSYNC, SLF_MI:
            begin
               if (bit_en && enc_last)
               begin
                  if (cnt_q != 32'h0)
                  begin
                     cnt_q  <= cnt_q - 32'h1;
                     sidx_q <= sidx_q + 5'h01;
                  end
                  else if (state_q == SLF_FSYNC)
                  begin
                     state_q <= SLF_MI;
                     cnt_q   <= 32'(i_mi_bits) - 32'h1;
                     sidx_q  <= 5'h00;
                  end
                  else
                  begin
                     state_q <= SLF_PHASE;
                     cnt_q   <= i_phasing_bits;
                     phase_q <= 1'b1;
                  end
               end
            end
            SLF_PHASE:
            begin
               if (bit_en)
               begin
                  phase_q <= ~phase_q;
                  if (last_bit)
                  begin
                     state_q <= SLF_TSYNC;
                     cnt_q   <= i_tsync_bits;
                  end
                  else
                  begin
                     cnt_q <= cnt_q - 32'h1;
                  end
               end
            end
            SLF_TSYNC:
            begin
               if (bit_en)
               begin
                  if (last_bit)
                  begin
                     state_q <= SLF_DATA;
                     cnt_q   <= i_data_bits;
                  end
                  else
                  begin
                     cnt_q <= cnt_q - 32'h1;
                  end
               end
            end
            SLF_DATA:
            begin
               if (bit_en)
               begin
                  if (last_bit)
                  begin
                     state_q <= SLF_POST;
                     cnt_q   <= i_post_bits;
                  end
                  else
                  begin
                     cnt_q <= cnt_q - 32'h1;
                  end
               end
            end
            SLF_POST:
            begin
               if (bit_en)
               begin
                  if (last_bit)
                  begin
                     state_q <= SLF_IDLE;
                  end
                  else
                  begin
                     cnt_q <= cnt_q - 32'h1;
                  end
               end
            end
            default:
            begin
               state_q <= SLF_IDLE;
            end
         endcase
      end
   end

   // take strobes: one per bit in each streamed field
   assign o_mi_take    = enc_load && enc_mi;
   assign o_tsync_take = bit_en && state_q == SLF_TSYNC && cnt_q != 32'h0;
   assign o_data_take  = bit_en && state_q == SLF_DATA && cnt_q != 32'h0;
   assign o_post_take  = bit_en && state_q == SLF_POST && cnt_q != 32'h0;

   // line output register
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         tx_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            SLF_BITSYNC: tx_q <= ~half_q;
            SLF_FSYNC:   tx_q <= enc_chip;
            SLF_MI:      tx_q <= enc_chip;
            SLF_PHASE:   tx_q <= (cnt_q == 32'h0) ? 1'b0 : phase_q;
            SLF_TSYNC:   tx_q <= i_tsync_bit;
            SLF_DATA:    tx_q <= i_data_bit;
            SLF_POST:    tx_q <= i_post_bit;
            default:     tx_q <= 1'b0;
         endcase
      end
   end

   // status outputs
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= bit_en && state_q == SLF_POST && last_bit;
      end
   end

   assign o_tx_data = tx_q;
   assign o_busy    = (state_q != SLF_IDLE);
   assign o_field   = state_q;

endmodule : slf_frame_builder

// >>> verilog/slf_rep_encoder.sv
/*
 * slf_rep_encoder: expands one data bit into its 15-bit repetition pattern,
 * msb first, one chip per bit enable.
 * Assumes i_load only arrives while o_last is high.
 */
module slf_rep_encoder
   import slf_pkg::*;
(
   input  wire logic i_mclk,     // system clock
   input  wire logic i_resetn,   // synchronous reset, active low
   input  wire logic i_bit_en,   // data-rate bit enable
   input  wire logic i_load,     // start a new group (with i_bit_en)
   input  wire logic i_data,     // data bit to encode
   output logic      o_chip,     // current chip
   output logic      o_last      // last chip of the group is on the line
);

   logic [14:0] shift_q;
   logic [3:0]  cnt_q;

   // load pattern and shift it out msb first
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         shift_q <= 15'h0000;
         cnt_q   <= 4'h0;
      end
      else if (i_bit_en)
      begin
         if (i_load)
         begin
            // complementary patterns keep a per-group majority vote possible at the far end
            shift_q <= i_data ? REP_ONE_PAT : REP_ZERO_PAT;
            cnt_q   <= 4'(REP_LEN - 1);
         end
         else if (cnt_q != 4'h0)
         begin
            shift_q <= {shift_q[13:0], 1'b0};
            cnt_q   <= cnt_q - 4'h1;
         end
      end
   end

   assign o_chip = shift_q[14];
   assign o_last = (cnt_q == 4'h0);

endmodule : slf_rep_encoder
